/* time_prop_pkg.sv */
// shared constants, field layouts and types of the time-proportioning output
package time_prop_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_REQ = 8'h04;
  localparam logic [7:0] REG_PERIOD = 8'h08;
  localparam logic [7:0] REG_LOW = 8'h0c;
  localparam logic [7:0] REG_HIGH = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_VAR_BIT = 0;
  localparam int unsigned CTRL_RELAY_BIT = 1;
  localparam int unsigned REQ_DIG_BIT = 16;
  localparam int unsigned REQ_ON_BIT = 17;
  localparam int unsigned STAT_OUT_BIT = 16;
  localparam int unsigned STAT_STATE_LSB = 20;

  // ----------------------------------------------------------------------
  // value limits and reset values (percent and seconds in tenths)
  // ----------------------------------------------------------------------
  localparam logic [9:0] PCT_FULL = 10'h3e8;
  localparam logic [9:0] PERIOD_SSR_MIN = 10'h001;
  localparam logic [9:0] PERIOD_RELAY_MIN = 10'h032;
  localparam logic [9:0] PERIOD_MAX = 10'h258;
  localparam logic [9:0] PERIOD_RST = 10'h032;
  localparam logic [9:0] LOW_RST = 10'h000;
  localparam logic [9:0] HIGH_RST = 10'h3e8;
  localparam logic [15:0] MS_PER_TENTH = 16'h0064;
  localparam logic [1:0] GROUP_LAST = 2'h2;

  // ----------------------------------------------------------------------
  // timing: the fixed time base is counted in millisecond steps
  // ----------------------------------------------------------------------
  localparam int unsigned CLOCK_NS = 50;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = (MS_NS + CLOCK_NS - 1) / CLOCK_NS;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic var_mode;
    logic relay;
    logic [9:0] period;
    logic [9:0] low;
    logic [9:0] high;
  } config_type;

  typedef struct packed {
    logic digital;
    logic on;
    logic [9:0] pct;
  } request_type;

  typedef enum logic [2:0] {
    ST_HOLD = 3'h1,
    ST_FIXED = 3'h2,
    ST_VAR = 3'h4
  } drive_state_type;

endpackage

/* power_scaler.sv */
// linear power scaling between the low and high power limits
module power_scaler (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [9:0] pct,
  input wire logic [9:0] low,
  input wire logic [9:0] high,
  output logic [9:0] scaled
);

  // ----------------------------------------------------------------------
  // interpolation
  // ----------------------------------------------------------------------
  logic [9:0] scaled_ff;
  logic [9:0] nxt_scaled;
  logic signed [11:0] span;
  logic signed [23:0] prod;
  logic signed [23:0] step;
  logic signed [11:0] sum;

  // (R9) signed span times percent; division truncates toward zero
  assign span = $signed({2'h0, high}) - $signed({2'h0, low});
  assign prod = 24'(span) * $signed({14'h0000, pct});
  assign step = prod / 24'sd1000;
  // (R7) (R8) ends land exactly on low and high, never outside them
  assign sum = $signed({2'h0, low}) + 12'(step);
  assign nxt_scaled = sum[9:0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scaled_ff <= 10'h000;
    end else begin
      scaled_ff <= nxt_scaled;
    end
  end

  assign scaled = scaled_ff;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_zero_to_low: assert property (@(posedge clock) // (R7)
    disable iff (!rst_n) pct == 10'h000 |=> scaled == $past(low))
    else $error("zero percent did not give the low limit");
  a_full_to_high: assert property (@(posedge clock) // (R8)
    disable iff (!rst_n) pct == 10'h3e8 |=> scaled == $past(high))
    else $error("full percent did not give the high limit");
  a_scale_between: assert property (@(posedge clock) // (R9)
    disable iff (!rst_n) pct <= 10'h3e8
    |=> (scaled >= $past(low) || scaled >= $past(high))
      && (scaled <= $past(low) || scaled <= $past(high)))
    else $error("scaled power outside the two limits");

endmodule

/* time_proportioning_output.sv */
// time-proportioning output driver with register port and line-cycle input
//
// What this block does
// (R1) a digital off or 0 percent request holds the output off, a digital on or 100 percent holds it on.
// (R2) between the extremes the output is switched so its average on time matches the power.
// (R3) fixed time base mode is on for the power fraction of each configured period, then off, repeating.
// (R4) variable time base mode switches on whole line cycles, at most every three cycles.
// (R5) solid-state outputs take a fixed period of 0.1 to 60.0 seconds, used only in fixed mode.
// (R6) relay outputs use only the fixed time base, with a period of 5.0 to 60.0 seconds.
// (R7) a 0 percent request maps to the low power limit.
// (R8) a 100 percent request maps to the high power limit.
// (R9) requests in between are interpolated linearly between the two limits.
// (R10) both limits are held from 0.0 to 100.0 percent in tenths.
// (R11) software should not pick the variable time base for relays or awkward loads.
// (R12) a new scaled duty is taken only at the start of a period or cycle group.
//
// Added by the designer: the plain strobed port and the register addresses.
module time_proportioning_output #(
  parameter int unsigned ms_cycles = time_prop_pkg::MS_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic line_sync,
  output logic load_on
);

  // ----------------------------------------------------------------------
  // clamping helpers
  // ----------------------------------------------------------------------
  // (R10) percentages above full scale are cut to full scale
  function automatic logic [9:0] clamp_pct(input logic [9:0] v);
    clamp_pct = (v > time_prop_pkg::PCT_FULL) ? time_prop_pkg::PCT_FULL : v;
  endfunction

  // (R5) (R6) the lower period bound depends on the output type
  function automatic logic [9:0] clamp_period(input logic [9:0] v,
                                              input logic relay);
    logic [9:0] lo;
    lo = relay ? time_prop_pkg::PERIOD_RELAY_MIN
               : time_prop_pkg::PERIOD_SSR_MIN;
    if (v < lo) begin
      clamp_period = lo;
    end else if (v > time_prop_pkg::PERIOD_MAX) begin
      clamp_period = time_prop_pkg::PERIOD_MAX;
    end else begin
      clamp_period = v;
    end
  endfunction

  // ----------------------------------------------------------------------
  // registers and declarations
  // ----------------------------------------------------------------------
  time_prop_pkg::config_type cfg_ff, nxt_cfg;
  time_prop_pkg::request_type req_ff, nxt_req;
  time_prop_pkg::drive_state_type state_ff, nxt_state, want_state;
  logic [31:0] rdata_ff, nxt_rdata, status_word;
  logic sync1_ff, sync2_ff, sync3_ff;
  logic [15:0] ms_div_ff, nxt_ms_div, ms_cnt_ff, nxt_ms_cnt;
  logic [15:0] per_ms_ff, eff_per_ms;
  logic [9:0] duty_ff, eff_period, acc_ff, scaled;
  logic [1:0] line_cnt_ff, nxt_line_cnt;
  logic [10:0] acc_sum;
  logic burst_ff, out_ff, nxt_out;
  logic wr_ctrl, wr_req, wr_period, wr_low, wr_high;
  logic hold_req, hold_level, var_eff, ms_tick, period_end;
  logic line_edge, group_end, start_fixed, start_group, fixed_on;
  logic [25:0] on_thresh, pos_scaled;

  // ----------------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------------
  assign wr_ctrl = wr_en && addr == time_prop_pkg::REG_CTRL;
  assign wr_req = wr_en && addr == time_prop_pkg::REG_REQ;
  assign wr_period = wr_en && addr == time_prop_pkg::REG_PERIOD;
  assign wr_low = wr_en && addr == time_prop_pkg::REG_LOW;
  assign wr_high = wr_en && addr == time_prop_pkg::REG_HIGH;

  // configuration next value; period, low and high writes store a clamped field
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_ctrl) begin
      nxt_cfg.var_mode = wdata[time_prop_pkg::CTRL_VAR_BIT];
      nxt_cfg.relay = wdata[time_prop_pkg::CTRL_RELAY_BIT];
    end
    if (wr_period) begin
      nxt_cfg.period = clamp_period(wdata[9:0], cfg_ff.relay);
    end
    if (wr_low) begin
      nxt_cfg.low = clamp_pct(wdata[9:0]);
    end
    if (wr_high) begin
      nxt_cfg.high = clamp_pct(wdata[9:0]);
    end
  end

  // request next value; a wide percent field would wrap, so it is clamped
  always_comb begin
    nxt_req = req_ff;
    if (wr_req) begin
      nxt_req.digital = wdata[time_prop_pkg::REQ_DIG_BIT];
      nxt_req.on = wdata[time_prop_pkg::REQ_ON_BIT];
      nxt_req.pct = clamp_pct(wdata[9:0]);
    end
  end

  // status shows scaled power, output level and drive state
  assign status_word = {9'h000, state_ff, 3'h0, out_ff, 6'h00, scaled};

  // read data stand one cycle only; unmapped addresses read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        time_prop_pkg::REG_CTRL: begin
          nxt_rdata = {30'h0000_0000, cfg_ff.relay, cfg_ff.var_mode};
        end
        time_prop_pkg::REG_REQ: begin
          nxt_rdata = {14'h0000, req_ff.on, req_ff.digital, 6'h00,
                       req_ff.pct};
        end
        time_prop_pkg::REG_PERIOD: begin
          nxt_rdata = {22'h00_0000, cfg_ff.period};
        end
        time_prop_pkg::REG_LOW: begin
          nxt_rdata = {22'h00_0000, cfg_ff.low};
        end
        time_prop_pkg::REG_HIGH: begin
          nxt_rdata = {22'h00_0000, cfg_ff.high};
        end
        time_prop_pkg::REG_STATUS: begin
          nxt_rdata = status_word;
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= '{var_mode: 1'b0, relay: 1'b0,
                  period: time_prop_pkg::PERIOD_RST,
                  low: time_prop_pkg::LOW_RST,
                  high: time_prop_pkg::HIGH_RST};
      req_ff <= '{digital: 1'b0, on: 1'b0, pct: 10'h000};
      rdata_ff <= 32'h0000_0000;
    end else begin
      cfg_ff <= nxt_cfg;
      req_ff <= nxt_req;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // power scaling
  // ----------------------------------------------------------------------
  // (R7) (R8) (R9) one cycle of latency between request and scaled power
  power_scaler scaler (
    .clock(clock),
    .rst_n(rst_n),
    .pct(req_ff.pct),
    .low(cfg_ff.low),
    .high(cfg_ff.high),
    .scaled(scaled)
  );

  // ----------------------------------------------------------------------
  // line-cycle input
  // ----------------------------------------------------------------------
  // the pin is asynchronous; the edge is taken between stages two and three
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= line_sync;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign line_edge = sync2_ff && !sync3_ff;

  // ----------------------------------------------------------------------
  // drive state
  // ----------------------------------------------------------------------
  // (R1) extremes bypass the time base and apply at once
  assign hold_req = req_ff.digital || req_ff.pct == 10'h000
                    || req_ff.pct >= time_prop_pkg::PCT_FULL;
  assign hold_level = req_ff.digital ? req_ff.on
                      : req_ff.pct >= time_prop_pkg::PCT_FULL;
  // (R6) a relay output never starts the variable time base
  assign var_eff = cfg_ff.var_mode && !cfg_ff.relay;
  assign want_state = hold_req ? time_prop_pkg::ST_HOLD
                      : var_eff ? time_prop_pkg::ST_VAR
                      : time_prop_pkg::ST_FIXED;

  // (R12) a change between time bases waits for the running period or group to end
  always_comb begin
    case (state_ff)
      time_prop_pkg::ST_HOLD: begin
        nxt_state = want_state;
      end
      time_prop_pkg::ST_FIXED: begin
        nxt_state = (hold_req || period_end) ? want_state : state_ff;
      end
      time_prop_pkg::ST_VAR: begin
        nxt_state = (hold_req || group_end) ? want_state : state_ff;
      end
      default: begin
        nxt_state = time_prop_pkg::ST_HOLD;
      end
    endcase
  end

  assign start_fixed = nxt_state == time_prop_pkg::ST_FIXED
                       && (state_ff != time_prop_pkg::ST_FIXED || period_end);
  assign start_group = nxt_state == time_prop_pkg::ST_VAR
                       && (state_ff != time_prop_pkg::ST_VAR || group_end);

  // ----------------------------------------------------------------------
  // fixed time base
  // ----------------------------------------------------------------------
  // (R5) (R6) the period is clamped again at use, in case the type changed
  assign eff_period = clamp_period(cfg_ff.period, cfg_ff.relay);
  assign eff_per_ms = 16'({6'h00, eff_period} * time_prop_pkg::MS_PER_TENTH);
  assign ms_tick = ms_div_ff >= 16'(ms_cycles - 1);
  assign period_end = ms_tick && ms_cnt_ff >= per_ms_ff - 16'h0001;
  assign nxt_ms_div = (start_fixed || ms_tick) ? 16'h0000
                      : ms_div_ff + 16'h0001;
  assign nxt_ms_cnt = start_fixed ? 16'h0000
                      : ms_tick ? ms_cnt_ff + 16'h0001 : ms_cnt_ff;

  // (R3) on while elapsed/period is below duty/1000, off for the rest
  assign on_thresh = {10'h000, per_ms_ff} * {16'h0000, duty_ff};
  assign pos_scaled = {10'h000, ms_cnt_ff} * 26'h00003e8;
  assign fixed_on = pos_scaled < on_thresh;

  // (R12) period length and duty are latched only as a period begins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ms_div_ff <= 16'h0000;
      ms_cnt_ff <= 16'h0000;
      per_ms_ff <= 16'h0001;
      duty_ff <= 10'h000;
    end else begin
      ms_div_ff <= nxt_ms_div;
      ms_cnt_ff <= nxt_ms_cnt;
      per_ms_ff <= start_fixed ? eff_per_ms : per_ms_ff;
      duty_ff <= start_fixed ? scaled : duty_ff;
    end
  end

  // ----------------------------------------------------------------------
  // variable time base
  // ----------------------------------------------------------------------
  // (R4) three line cycles per group, each group wholly on or off
  assign group_end = line_edge && line_cnt_ff == time_prop_pkg::GROUP_LAST;
  assign nxt_line_cnt = start_group ? 2'h0
                        : line_edge ? line_cnt_ff + 2'h1 : line_cnt_ff;
  // (R2) the residue carries over, so the long-run average is exact
  assign acc_sum = {1'b0, acc_ff} + {1'b0, scaled};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_cnt_ff <= 2'h0;
      acc_ff <= 10'h000;
      burst_ff <= 1'b0;
    end else begin
      line_cnt_ff <= nxt_line_cnt;
      if (start_group) begin
        burst_ff <= acc_sum >= {1'b0, time_prop_pkg::PCT_FULL};
        acc_ff <= (acc_sum >= {1'b0, time_prop_pkg::PCT_FULL})
                  ? 10'(acc_sum - {1'b0, time_prop_pkg::PCT_FULL})
                  : acc_sum[9:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // output
  // ----------------------------------------------------------------------
  // (R1) (R2) output follows the state with one cycle of register delay
  assign nxt_out = (state_ff == time_prop_pkg::ST_HOLD) ? hold_level
                   : (state_ff == time_prop_pkg::ST_FIXED) ? fixed_on
                   : burst_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= time_prop_pkg::ST_HOLD;
      out_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      out_ff <= nxt_out;
    end
  end

  assign rdata = rdata_ff;
  assign load_on = out_ff;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_off_request: assert property (@(posedge clock) // (R1)
    disable iff (!rst_n) (hold_req && !hold_level)[*3] |-> !out_ff)
    else $error("output not off under an off request");
  a_on_request: assert property (@(posedge clock) // (R1)
    disable iff (!rst_n) (hold_req && hold_level)[*3] |-> out_ff)
    else $error("output not on under a full request");
  a_period_starts_on: assert property (@(posedge clock) // (R3)
    disable iff (!rst_n) state_ff == time_prop_pkg::ST_FIXED
    && ms_cnt_ff == 16'h0000 && duty_ff != 10'h000 |=> out_ff)
    else $error("fixed period did not begin on");
  a_zero_duty_off: assert property (@(posedge clock) // (R2)
    disable iff (!rst_n)
    state_ff == time_prop_pkg::ST_FIXED && duty_ff == 10'h000 |=> !out_ff)
    else $error("zero duty drove the output on");
  a_period_restart: assert property (@(posedge clock) // (R3)
    disable iff (!rst_n)
    start_fixed |=> ms_cnt_ff == 16'h0000 && per_ms_ff == $past(eff_per_ms))
    else $error("fixed period did not restart");
  // relay is judged at the start edge, where the period length was chosen
  a_period_bounds: assert property (@(posedge clock) // (R6)
    disable iff (!rst_n) start_fixed && cfg_ff.relay
    |=> per_ms_ff >= 16'h1388 && per_ms_ff <= 16'hea60)
    else $error("relay period outside its range");
  a_ssr_bounds: assert property (@(posedge clock) // (R5)
    disable iff (!rst_n)
    start_fixed |=> per_ms_ff >= 16'h0064 && per_ms_ff <= 16'hea60)
    else $error("fixed period outside its range");
  a_var_group_run: assert property (@(posedge clock) // (R4)
    disable iff (!rst_n) state_ff == time_prop_pkg::ST_VAR && !start_group
    |=> $stable(burst_ff) && $stable(acc_ff))
    else $error("variable output switched inside a group");
  a_relay_no_var: assert property (@(posedge clock) // (R6)
    disable iff (!rst_n) cfg_ff.relay && state_ff != time_prop_pkg::ST_VAR
    |=> state_ff != time_prop_pkg::ST_VAR)
    else $error("relay output entered the variable time base");
  a_duty_held: assert property (@(posedge clock) // (R12)
    disable iff (!rst_n) state_ff == time_prop_pkg::ST_FIXED && !start_fixed
    |=> $stable(duty_ff))
    else $error("duty changed inside a running period");
  a_limit_range: assert property (@(posedge clock) // (R10)
    disable iff (!rst_n)
    wr_low || wr_high |=> cfg_ff.low <= 10'h3e8 && cfg_ff.high <= 10'h3e8)
    else $error("power limit stored above full scale");

  c_period_end: cover property (@(posedge clock) disable iff (!rst_n)
    state_ff == time_prop_pkg::ST_FIXED && period_end);
  c_var_burst: cover property (@(posedge clock) disable iff (!rst_n)
    state_ff == time_prop_pkg::ST_VAR && start_group && !burst_ff);
  c_hold_on: cover property (@(posedge clock) disable iff (!rst_n)
    state_ff == time_prop_pkg::ST_HOLD && out_ff);

endmodule

/* load_model.sv */
// load switch model: ac line source and on-time meter for the load
module load_model (
  input wire logic clock,
  input wire logic load_on,
  output logic line_sync,
  output int on_cnt,
  output int sw_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  int ph = 0;
  int on_q = 0;
  int sw_q = 0;
  logic last = 1'b0;

  // counters start at zero by declaration, so each keeps one driver
  assign on_cnt = on_q;
  assign sw_cnt = sw_q;

  // whole line cycles
  // mains runs free: 20 clocks high, 20 low make one line cycle
  always @(posedge clock) begin
    ph <= (ph == 39) ? 0 : ph + 1;
  end
  assign line_sync = (ph >= 20);

  // average on time
  // counts on clocks and switch events; the bench takes differences
  always @(posedge clock) begin
    if (load_on === 1'b1) on_q <= on_q + 1;
    if (load_on !== last) sw_q <= sw_q + 1;
    last <= load_on;
  end
endmodule

/* time_proportioning_output_bench.sv */
// register-driven bench for the time-proportioning output
module time_proportioning_output_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic line_sync;
  logic load_on;
  int on_cnt;
  int sw_cnt;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] v;
  int on0;
  int sw0;
  logic [31:0] reqs [4] = '{32'h3_0000, 32'h1_03e8, 32'h3e8, 32'h0};
  logic [3:0] lvls = 4'b0101;
  logic [9:0] pcts [4] = '{10'h000, 10'h3e8, 10'h0fa, 10'h1f4};
  logic [9:0] scls [4] = '{10'h0c8, 10'h320, 10'h15e, 10'h1f4};

  always #25 clock = ~clock;

  // short millisecond step keeps the periods in reach of simulation
  time_proportioning_output #(.ms_cycles(4)) time_proportioning_output_inst (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .line_sync(line_sync), .load_on(load_on));

  load_model load_model_inst (.clock(clock), .load_on(load_on),
    .line_sync(line_sync), .on_cnt(on_cnt), .sw_cnt(sw_cnt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    // step off the edge so a following strobe is not set in this time step
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  // on-time over n clocks must sit within tol tenths of pct tenths
  task automatic meas(input int n, input int pct, input int tol);
    int d;
    on0 = on_cnt;
    sw0 = sw_cnt;
    repeat (n) @(posedge clock);
    d = (on_cnt - on0) * 1000 - pct * n;
    check({31'h0, d <= tol * n && d >= -tol * n}, 32'h1);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(50 * 60000);
    num_errors++;
    $display("[ERR] %0t watchdog ran out", $time);
    print_verdict;
  end

  initial begin
    repeat (6) @(posedge clock);
    @(negedge clock) rst_n <= 1'b1;
    @(posedge clock);
    // reset values, unmapped and read-only places
    rd(time_prop_pkg::REG_CTRL, v);
    check(v, 32'h0);
    rd(time_prop_pkg::REG_PERIOD, v);
    check(v, 32'h32);
    rd(time_prop_pkg::REG_HIGH, v);
    check(v, 32'h3e8);
    rd(8'h18, v);
    check(v, 32'h0);
    wr(time_prop_pkg::REG_STATUS, 32'hffff_ffff);
    rd(time_prop_pkg::REG_STATUS, v);
    check(v, 32'h0010_0000);
    $display("test reset done");
    // digital and extreme requests act on the output directly
    for (int i = 0; i < 4; i++) begin
      wr(time_prop_pkg::REG_REQ, reqs[i]);
      repeat (2) @(posedge clock);
      #1 check({31'h0, load_on}, {31'h0, lvls[i]});
    end
    $display("test extremes done");
    // scaling between limits of 20.0 and 80.0 percent
    wr(time_prop_pkg::REG_PERIOD, 32'h1);
    wr(time_prop_pkg::REG_LOW, 32'hc8);
    wr(time_prop_pkg::REG_HIGH, 32'h320);
    for (int i = 0; i < 4; i++) begin
      wr(time_prop_pkg::REG_REQ, {22'h0, pcts[i]});
      repeat (3) @(posedge clock);
      rd(time_prop_pkg::REG_STATUS, v);
      check({22'h0, v[9:0]}, {22'h0, scls[i]});
    end
    wr(time_prop_pkg::REG_LOW, 32'h7ff);
    rd(time_prop_pkg::REG_LOW, v);
    check(v, 32'h3e8);
    wr(time_prop_pkg::REG_LOW, 32'h0);
    wr(time_prop_pkg::REG_HIGH, 32'h3e8);
    $display("test scaling done");
    // fixed base of 0.1 s: ten whole periods in each window
    for (int i = 2; i < 4; i++) begin
      wr(time_prop_pkg::REG_REQ, {22'h0, pcts[i]});
      repeat (800) @(posedge clock);
      meas(4000, int'(pcts[i]), 10);
    end
    rd(time_prop_pkg::REG_STATUS, v);
    check({29'h0, v[22:20]}, 32'h2);
    $display("test fixed done");
    // variable base on groups of three line cycles
    // variable base is chosen only with a solid-state output
    wr(time_prop_pkg::REG_CTRL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wr(time_prop_pkg::REG_REQ, i ? 32'h29a : 32'h1f4);
      repeat (800) @(posedge clock);
      meas(4800, i ? 666 : 500, 30);
      check({31'h0, sw_cnt - sw0 <= 41}, 32'h1);
    end
    rd(time_prop_pkg::REG_STATUS, v);
    check({29'h0, v[22:20]}, 32'h4);
    $display("test variable done");
    // relay leaves the variable base and clamps its period
    // the write that selects a relay clears the variable bit; the drive state leaves the variable base only at the end of the running group
    wr(time_prop_pkg::REG_CTRL, 32'h2);
    wr(time_prop_pkg::REG_PERIOD, 32'h1);
    rd(time_prop_pkg::REG_PERIOD, v);
    check(v, 32'h32);
    wr(time_prop_pkg::REG_PERIOD, 32'h3ff);
    rd(time_prop_pkg::REG_PERIOD, v);
    check(v, 32'h258);
    repeat (800) @(posedge clock);
    rd(time_prop_pkg::REG_STATUS, v);
    check({29'h0, v[22:20]}, 32'h2);
    wr(time_prop_pkg::REG_CTRL, 32'h0);
    wr(time_prop_pkg::REG_PERIOD, 32'h0);
    rd(time_prop_pkg::REG_PERIOD, v);
    check(v, 32'h1);
    $display("test relay done");
    print_verdict;
  end
endmodule
